//--- fpc_regs.svh
// Constants for the flash program/erase host controller.
// Assumes a 10 MHz ref_clk_i; counts derive from the times below.
`ifndef FPC_REGS_SVH
`define FPC_REGS_SVH

// ==========================================================
// Clock
`define FPC_CLK_NS 100
// ==========================================================
// Command addresses and data
`define FPC_ADDR_UNLOCK1 20'h00555
`define FPC_ADDR_UNLOCK2 20'h002aa
`define FPC_DATA_UNLOCK1 8'haa
`define FPC_DATA_UNLOCK2 8'h55
`define FPC_DATA_ERASE_SETUP 8'h80
`define FPC_DATA_CHIP_ERASE 8'h10
`define FPC_DATA_SECTOR_ERASE 8'h30
`define FPC_DATA_PROGRAM 8'ha0
`define FPC_DATA_SUSPEND 8'hb0
`define FPC_DATA_RESUME 8'hd0
`define FPC_DATA_ID_ENTRY 8'h90
`define FPC_DATA_ID_EXIT 8'hf0
`define FPC_DATA_LOCKDOWN 8'h60
`define FPC_ADDR_MFR_CODE 20'h00000
`define FPC_ADDR_DEV_CODE 20'h00001
`define FPC_ADDR_ADD_CODE 20'h00003
// ==========================================================
// Times, in natural units
`define FPC_T_PROG_US 200
`define FPC_T_PROG_FAST_US 100
`define FPC_T_SEC_ERASE_MS 400
`define FPC_T_CHIP_ERASE_S 12
`define FPC_T_CHIP_ERASE_FAST_S 6
`define FPC_T_SUSPEND_US 15
`define FPC_T_WP_NS 40
`define FPC_T_WPH_NS 30
`define FPC_T_OEHP_NS 50
// Derived cycle counts, least times round up
`define FPC_WP_CYC ((`FPC_T_WP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_WPH_CYC ((`FPC_T_WPH_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_OEHP_CYC ((`FPC_T_OEHP_NS + `FPC_CLK_NS - 1) / `FPC_CLK_NS)
`define FPC_SUSPEND_CYC ((`FPC_T_SUSPEND_US * 1000 + `FPC_CLK_NS - 1) / `FPC_CLK_NS)

`endif

//--- fpc_pkg.sv
// Types for the flash program/erase host controller.
// Assumes fpc_regs.svh supplies all numbers.
package fpc_pkg;
  typedef enum logic [2:0] {
    FPC_OP_READ = 3'h0,
    FPC_OP_PROGRAM = 3'h1,
    FPC_OP_CHIP_ERASE = 3'h2,
    FPC_OP_SECTOR_ERASE = 3'h3,
    FPC_OP_ID_READ = 3'h4,
    FPC_OP_ID_EXIT = 3'h5,
    FPC_OP_LOCKDOWN = 3'h6,
    FPC_OP_SUSPEND = 3'h7
  } fpc_op_e;
endpackage

//--- fpc_bus_cycle.sv
// One asynchronous flash bus cycle: write or read, on chip select,
// write enable and output enable. Assumes inputs synchronous to ref_clk_i.
`timescale 1ns/100ps
`include "fpc_regs.svh"
module fpc_bus_cycle #(
  parameter int WP_CYC = `FPC_WP_CYC,
  parameter int GAP_CYC = `FPC_OEHP_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [19:0] addr_i,
  input wire logic [15:0] wdata_i,
  output logic busy_o,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic [19:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i
);
  // ==========================================================
  // Cycle sequencer
  typedef enum logic [2:0] {
    FPC_BC_IDLE = 3'b001,
    FPC_BC_STROBE = 3'b010,
    FPC_BC_GAP = 3'b100
  } fpc_bc_e;
  fpc_bc_e state, next_state;
  logic [7:0] cnt, next_cnt;
  logic wr, next_wr;
  logic [19:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic done, next_done;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_wr = wr;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_done = 1'b0;
    case (state)
      FPC_BC_IDLE: begin
        if (start_i) begin
          next_state = FPC_BC_STROBE;
          next_wr = write_i;
          next_addr = addr_i;
          next_wdata = write_i ? {8'h00, wdata_i[7:0]} : 16'h0000;
          next_cnt = 8'(WP_CYC);
        end
      end
      FPC_BC_STROBE: begin
        if (cnt <= 8'h01) begin
          // Sample at end of strobe; each strobe is a fresh status read
          if (!wr) next_rdata = flash_dq_i;
          next_state = FPC_BC_GAP;
          next_cnt = 8'(GAP_CYC);
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      FPC_BC_GAP: begin
        // High gap meets write-high and toggle high-pulse minimums
        if (cnt <= 8'h01) begin
          next_state = FPC_BC_IDLE;
          next_done = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: next_state = FPC_BC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state <= FPC_BC_IDLE;
      cnt <= 8'h00;
      wr <= 1'b0;
      addr <= 20'h00000;
      wdata <= 16'h0000;
      rdata <= 16'h0000;
      done <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      wr <= next_wr;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      done <= next_done;
    end
  end

  assign busy_o = (state != FPC_BC_IDLE);
  assign done_o = done;
  assign rdata_o = rdata;
  assign flash_addr_o = addr;
  assign flash_ce_n_o = (state != FPC_BC_STROBE);
  // Output enable held high through every write strobe
  assign flash_oe_n_o = !((state == FPC_BC_STROBE) && !wr);
  assign flash_we_n_o = !((state == FPC_BC_STROBE) && wr);
  assign flash_dq_o = wdata;
  assign flash_dq_oe_o = wr && (state != FPC_BC_IDLE);
endmodule

//--- fpc_flash_host.sv
// Host controller driving a parallel NOR flash through its bus pins.
// Assumes flash inputs are synchronous to ref_clk_i; dq is split in/out/oe.
//
// How it works
// - Chip erase final write goes to 555
// - Final erase data 10 chip, 30 sector
// - Sector address selects sector; 400 ms limit
// - Output enable high during write strobes
// - Each output-enable toggle is fresh status read
// - Polling address stays constant per sequence
// - Judge only toggle-bit changes, not values
`timescale 1ns/100ps
`include "fpc_regs.svh"
module fpc_flash_host #(
  parameter int CLK_NS = `FPC_CLK_NS,
  parameter int PROG_CYC = `FPC_T_PROG_US * 1000 / `FPC_CLK_NS,
  parameter int PROG_FAST_CYC = `FPC_T_PROG_FAST_US * 1000 / `FPC_CLK_NS,
  parameter int SEC_ERASE_CYC = `FPC_T_SEC_ERASE_MS * 1000 * 10,
  parameter int CHIP_ERASE_CYC = `FPC_T_CHIP_ERASE_S * 1000 * 10000,
  parameter int CHIP_ERASE_FAST_CYC = `FPC_T_CHIP_ERASE_FAST_S * 1000 * 10000,
  parameter int SUSPEND_CYC = `FPC_SUSPEND_CYC
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire fpc_pkg::fpc_op_e req_op_i,
  input wire logic [19:0] req_addr_i,
  input wire logic [15:0] req_data_i,
  input wire logic fast_supply_i,
  output logic busy_o,
  output logic done_o,
  output logic timeout_o,
  output logic [15:0] rdata_o,
  output logic [19:0] flash_addr_o,
  output logic flash_ce_n_o,
  output logic flash_oe_n_o,
  output logic flash_we_n_o,
  output logic [15:0] flash_dq_o,
  output logic flash_dq_oe_o,
  input wire logic [15:0] flash_dq_i
);
  import fpc_pkg::*;

  // ==========================================================
  // Sequencer
  typedef enum logic [4:0] {
    FPC_IDLE = 5'b00001,
    FPC_WRITE = 5'b00010,
    FPC_POLL = 5'b00100,
    FPC_READ = 5'b01000,
    FPC_FINISH = 5'b10000
  } fpc_state_e;

  // Command step table: address and data of write number idx
  function automatic logic [27:0] fpc_step(input fpc_op_e op, input logic [2:0] idx, input logic [19:0] a,
                                           input logic [7:0] d);
    logic [27:0] s;
    s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_UNLOCK1};
    if (idx == 3'h1) s = {`FPC_ADDR_UNLOCK2, `FPC_DATA_UNLOCK2};
    if (idx == 3'h2) begin
      case (op)
        FPC_OP_PROGRAM: s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_PROGRAM};
        FPC_OP_ID_READ: s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_ID_ENTRY};
        FPC_OP_ID_EXIT: s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_ID_EXIT};
        default: s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_ERASE_SETUP};
      endcase
    end
    if (idx == 3'h3) begin
      if (op == FPC_OP_PROGRAM) s = {a, d};
      else s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_UNLOCK1};
    end
    if (idx == 3'h4) s = {`FPC_ADDR_UNLOCK2, `FPC_DATA_UNLOCK2};
    if (idx == 3'h5) begin
      case (op)
        FPC_OP_CHIP_ERASE: s = {`FPC_ADDR_UNLOCK1, `FPC_DATA_CHIP_ERASE};
        FPC_OP_SECTOR_ERASE: s = {a, `FPC_DATA_SECTOR_ERASE};
        default: s = {a, `FPC_DATA_LOCKDOWN};
      endcase
    end
    return s;
  endfunction

  // Number of writes in each command; suspend is listed as 0 but makes one write
  function automatic logic [2:0] fpc_len(input fpc_op_e op);
    case (op)
      FPC_OP_PROGRAM: fpc_len = 3'h4;
      FPC_OP_CHIP_ERASE, FPC_OP_SECTOR_ERASE, FPC_OP_LOCKDOWN: fpc_len = 3'h6;
      FPC_OP_SUSPEND, FPC_OP_READ: fpc_len = 3'h0;
      default: fpc_len = 3'h3;
    endcase
  endfunction

  function automatic logic [31:0] fpc_limit(input fpc_op_e op, input logic fast);
    case (op)
      FPC_OP_PROGRAM: fpc_limit = fast ? 32'(PROG_FAST_CYC) : 32'(PROG_CYC);
      FPC_OP_CHIP_ERASE: fpc_limit = fast ? 32'(CHIP_ERASE_FAST_CYC) : 32'(CHIP_ERASE_CYC);
      FPC_OP_SECTOR_ERASE: fpc_limit = 32'(SEC_ERASE_CYC);
      default: fpc_limit = 32'(SUSPEND_CYC);
    endcase
  endfunction

  fpc_state_e state, next_state;
  fpc_op_e op, next_op;
  logic [19:0] addr, next_addr;
  logic [7:0] data, next_data;
  logic [2:0] idx, next_idx;
  logic [31:0] timer, next_timer;
  logic have_prev, next_have_prev;
  logic prev_tog, next_prev_tog;
  logic [15:0] rdata, next_rdata;
  logic done, next_done;
  logic timeout, next_timeout;
  logic bc_start, bc_write, bc_busy, bc_done;
  logic [19:0] bc_addr;
  logic [15:0] bc_wdata, bc_rdata;
  logic [27:0] step;

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_idx = idx;
    next_timer = timer;
    next_have_prev = have_prev;
    next_prev_tog = prev_tog;
    next_rdata = rdata;
    next_done = 1'b0;
    next_timeout = timeout;
    bc_start = 1'b0;
    bc_write = 1'b0;
    step = fpc_step(op, idx, addr, data);
    bc_addr = step[27:8];
    bc_wdata = {8'h00, step[7:0]};
    case (state)
      FPC_IDLE: begin
        if (req_valid_i) begin
          next_op = req_op_i;
          next_addr = req_addr_i;
          next_data = req_data_i[7:0];
          next_idx = 3'h0;
          next_timeout = 1'b0;
          next_have_prev = 1'b0;
          next_timer = fpc_limit(req_op_i, fast_supply_i);
          if (req_op_i == FPC_OP_READ) next_state = FPC_READ;
          else if (req_op_i == FPC_OP_SUSPEND) next_state = FPC_WRITE;
          else next_state = FPC_WRITE;
        end
      end
      FPC_WRITE: begin
        if (op == FPC_OP_SUSPEND) begin
          bc_wdata = {8'h00, `FPC_DATA_SUSPEND};
          bc_addr = addr;
        end
        bc_write = 1'b1;
        bc_start = !bc_busy && !bc_done;
        if (bc_done) begin
          next_idx = idx + 3'h1;
          if ((idx + 3'h1 >= fpc_len(op)) || (op == FPC_OP_SUSPEND)) begin
            // ID entry ends with a code read, ID exit and lockdown need no wait
            if (op == FPC_OP_ID_READ) next_state = FPC_READ;
            else if (op == FPC_OP_ID_EXIT || op == FPC_OP_LOCKDOWN) next_state = FPC_FINISH;
            else next_state = FPC_POLL;
          end
        end
      end
      FPC_POLL: begin
        // Fixed address over the whole poll sequence
        bc_addr = addr;
        bc_start = !bc_busy && !bc_done;
        if (timer != 32'h0) next_timer = timer - 32'h1;
        if (bc_done) begin
          next_have_prev = 1'b1;
          next_prev_tog = bc_rdata[6];
          // Only a change between reads means busy; absolute value is ignored
          if (have_prev && (bc_rdata[6] == prev_tog)) begin
            next_rdata = bc_rdata;
            next_state = FPC_FINISH;
          end else if (timer == 32'h0) begin
            next_timeout = 1'b1;
            next_state = FPC_FINISH;
          end
        end
      end
      FPC_READ: begin
        // ID codes live in the low byte; addr_bit0 and address 3 select them
        bc_addr = addr;
        bc_start = !bc_busy && !bc_done;
        if (bc_done) begin
          next_rdata = bc_rdata;
          next_state = FPC_FINISH;
        end
      end
      FPC_FINISH: begin
        next_done = 1'b1;
        next_state = FPC_IDLE;
      end
      default: next_state = FPC_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state <= FPC_IDLE;
      op <= FPC_OP_READ;
      addr <= 20'h00000;
      data <= 8'h00;
      idx <= 3'h0;
      timer <= 32'h0;
      have_prev <= 1'b0;
      prev_tog <= 1'b0;
      rdata <= 16'h0000;
      done <= 1'b0;
      timeout <= 1'b0;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      idx <= next_idx;
      timer <= next_timer;
      have_prev <= next_have_prev;
      prev_tog <= next_prev_tog;
      rdata <= next_rdata;
      done <= next_done;
      timeout <= next_timeout;
    end
  end

  // ==========================================================
  // Bus cycle engine
  fpc_bus_cycle u_cycle (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(bc_start),
    .write_i(bc_write),
    .addr_i(bc_addr),
    .wdata_i(bc_wdata),
    .busy_o(bc_busy),
    .done_o(bc_done),
    .rdata_o(bc_rdata),
    .flash_addr_o(flash_addr_o),
    .flash_ce_n_o(flash_ce_n_o),
    .flash_oe_n_o(flash_oe_n_o),
    .flash_we_n_o(flash_we_n_o),
    .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o),
    .flash_dq_i(flash_dq_i)
  );

  assign req_ready_o = (state == FPC_IDLE);
  assign busy_o = (state != FPC_IDLE);
  assign done_o = done;
  assign timeout_o = timeout;
  assign rdata_o = rdata;
endmodule

//--- fpc_flash_host_assertions.sv
// Checker on the flash host controller ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module fpc_flash_host_chk (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic req_valid_i,
  input wire logic req_ready_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic [19:0] flash_addr_o,
  input wire logic flash_ce_n_o,
  input wire logic flash_oe_n_o,
  input wire logic flash_we_n_o,
  input wire logic [15:0] flash_dq_o,
  input wire logic flash_dq_oe_o
);
  localparam int MAX_OP = 1000;
  logic wr;
  logic rd;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic seen;
  logic next_seen;
  logic [19:0] rd_addr;
  logic [19:0] next_rd_addr;
  assign wr = !flash_ce_n_o && !flash_we_n_o;
  assign rd = !flash_ce_n_o && !flash_oe_n_o;
  // ==========================================================
  // Writes since erase setup; only the final one is judged
  always_comb begin
    next_cnt = cnt;
    if (wr) begin
      next_cnt = (flash_dq_o[7:0] == 8'h80 && flash_addr_o == 20'h00555) ? 2'd1 : (cnt == 2'd0 ? 2'd0 : cnt + 2'd1);
    end
    next_seen = busy_o && (seen || rd);
    next_rd_addr = rd ? flash_addr_o : rd_addr;
  end
  always_ff @(posedge ref_clk_i) begin
    cnt <= reset_n_i ? next_cnt : 2'd0;
    seen <= reset_n_i ? next_seen : 1'b0;
    rd_addr <= next_rd_addr;
  end
  // ==========================================================
  // Properties
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_take;
    req_valid_i && req_ready_o;
  endsequence
  sequence s_gap;
    flash_oe_n_o && flash_we_n_o;
  endsequence
  chk_oe_write_high: assert property (wr |-> flash_oe_n_o)
    else $error("oe low during write strobe");
  chk_write_gap: assert property (wr |=> s_gap)
    else $error("no gap after write strobe");
  chk_read_fresh: assert property (rd |=> s_gap)
    else $error("read strobe not ended after one cycle");
  chk_upper_byte: assert property (flash_dq_oe_o |-> flash_dq_o[15:8] == 8'h00)
    else $error("upper data byte driven");
  chk_erase_addr: assert property (wr && cnt == 2'd3 && flash_dq_o[7:0] == 8'h10 |-> flash_addr_o == 20'h00555)
    else $error("chip erase final write not at 555");
  chk_erase_code: assert property (wr && cnt == 2'd3 |-> flash_dq_o[7:0] inside {8'h10, 8'h30, 8'h60})
    else $error("bad final erase code");
  chk_poll_addr: assert property (busy_o && seen && rd |-> flash_addr_o == rd_addr)
    else $error("poll address changed");
  chk_take_done: assert property (s_take |-> ##[1:MAX_OP] done_o)
    else $error("request not finished in time");
  chk_done_pulse: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  chk_ready_idle: assert property (busy_o |-> !req_ready_o)
    else $error("ready while busy");
endmodule
bind fpc_flash_host fpc_flash_host_chk fpc_flash_host_chk_inst (.ref_clk_i, .reset_n_i, .req_valid_i, .req_ready_o,
  .busy_o, .done_o, .flash_addr_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_dq_o, .flash_dq_oe_o);

//--- fpc_flash_model.sv
// Behavioural flash device seen through its bus pins.
// Assumes strobes synchronous to clk_i; reset stands for power-up.
`timescale 1ns/100ps
module fpc_flash_model #(
  parameter logic [7:0] MFR = 8'h5e, // Arbitrary value
  parameter logic [7:0] DEV = 8'h71, // Arbitrary value
  parameter logic [7:0] ADD = 8'h2d // Arbitrary value
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [19:0] addr_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [15:0] dq_i,
  input wire logic [9:0] busy_reads_i,
  output logic [15:0] dq_o,
  output logic [2:0] evt_o,
  output logic [19:0] evt_addr_o,
  output logic [15:0] evt_data_o
);
  logic [7:0] d [0:2];
  logic id;
  logic tog;
  logic rd;
  logic [2:0] k;
  logic [9:0] cnt;
  logic [15:0] val;
  logic [15:0] last;
  assign rd = !ce_n_i && !oe_n_i;
  // Released bus shows inverse of last value, never a stale copy
  assign dq_o = rd ? val : ~last;
  always_comb begin
    if (cnt != 10'd0) val = {9'h000, tog, 6'h00};
    else if (id && addr_i == 20'h00000) val = {8'h00, MFR};
    else if (id && addr_i == 20'h00001) val = {8'h00, DEV};
    else if (id && addr_i == 20'h00003) val = {8'h00, ADD};
    else val = addr_i[15:0] ^ 16'h3c3c;
    k = 3'd0;
    if (d[0] == 8'ha0 && d[1] == 8'h55 && d[2] == 8'haa) k = 3'd1;
    else if (d[2] == 8'h80 && d[1] == 8'haa && dq_i[7:0] == 8'h10 && addr_i == 20'h00555) k = 3'd2;
    else if (d[2] == 8'h80 && d[1] == 8'haa && dq_i[7:0] == 8'h30) k = 3'd3;
    else if (d[2] == 8'h80 && d[1] == 8'haa && dq_i[7:0] == 8'h60) k = 3'd4;
    else if (dq_i[7:0] == 8'hb0) k = 3'd5;
  end
  always @(posedge clk_i) begin
    if (!reset_n_i) begin
      id <= 1'b0;
      tog <= 1'b1;
      cnt <= 10'd0;
      last <= 16'h0000;
      evt_o <= 3'd0;
    end else if (rd) begin
      last <= val;
      if (cnt != 10'd0) begin
        tog <= !tog;
        cnt <= cnt - 10'd1;
      end
    end else if (!we_n_i && !ce_n_i) begin
      d[2] <= d[1];
      d[1] <= d[0];
      d[0] <= dq_i[7:0];
      if (k != 3'd0) begin
        evt_o <= k;
        evt_addr_o <= addr_i;
        evt_data_o <= dq_i;
        if (k != 3'd4) cnt <= busy_reads_i;
      end
      if (k == 3'd0 && dq_i[7:0] == 8'h90 && d[0] == 8'h55 && d[1] == 8'haa) id <= 1'b1;
      // Single-write and three-write exit forms both end in f0
      if (k == 3'd0 && dq_i[7:0] == 8'hf0) id <= 1'b0;
    end
  end
endmodule

//--- fpc_flash_host_bench.sv
// Self-checking bench for the flash host controller.
// Assumes the flash model file and the bound checker are compiled alongside.
`timescale 1ns/100ps
module fpc_flash_host_bench;
  import fpc_pkg::*;
  logic ref_clk_i;
  logic reset_n_i;
  logic req_valid_i;
  logic req_ready_o;
  fpc_op_e req_op_i;
  logic [19:0] req_addr_i;
  logic [15:0] req_data_i;
  logic fast_supply_i;
  logic busy_o;
  logic done_o;
  logic timeout_o;
  logic [15:0] rdata_o;
  logic [19:0] flash_addr_o;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic [15:0] dq_o;
  logic dq_oe;
  logic [15:0] dq_in;
  logic [15:0] model_dq;
  logic [9:0] busy_reads;
  logic [2:0] evt;
  logic [19:0] evt_addr;
  logic [15:0] evt_data;
  int miscompares;
  int comparisons;
  int k;
  logic [31:0] seed;
  logic [19:0] a;
  logic [9:0] n;
  logic f;
  fpc_op_e ops [5] = '{FPC_OP_PROGRAM, FPC_OP_CHIP_ERASE, FPC_OP_SECTOR_ERASE, FPC_OP_LOCKDOWN, FPC_OP_SUSPEND};
  logic [7:0] codes [5] = '{8'h00, 8'h10, 8'h30, 8'h60, 8'hb0};
  logic [19:0] id_addr [3] = '{20'h00000, 20'h00001, 20'h00003};
  logic [7:0] id_code [3] = '{8'h5e, 8'h71, 8'h2d};
  assign dq_in = dq_oe ? dq_o : model_dq;
  always #50 ref_clk_i = ~ref_clk_i;
  // Suspend keeps its real 15 us limit; the long limits are shrunk to keep the run short
  fpc_flash_host #(.PROG_CYC(400), .PROG_FAST_CYC(200), .SEC_ERASE_CYC(400), .CHIP_ERASE_CYC(400),
    .CHIP_ERASE_FAST_CYC(200)) fpc_flash_host_inst (.ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_op_i(req_op_i),
    .req_addr_i(req_addr_i), .req_data_i(req_data_i), .fast_supply_i(fast_supply_i), .busy_o(busy_o),
    .done_o(done_o), .timeout_o(timeout_o), .rdata_o(rdata_o), .flash_addr_o(flash_addr_o), .flash_ce_n_o(ce_n),
    .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_in));
  fpc_flash_model fpc_flash_model_inst (.clk_i(ref_clk_i), .reset_n_i(reset_n_i), .addr_i(flash_addr_o),
    .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .dq_i(dq_in), .busy_reads_i(busy_reads), .dq_o(model_dq),
    .evt_o(evt), .evt_addr_o(evt_addr), .evt_data_o(evt_data));
  // ==========================================================
  // Expectations and checks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_to(input fpc_op_e op, input logic fs, input logic [9:0] nr);
    return nr > 10'd50 && (op == FPC_OP_SUSPEND || (fs && (op == FPC_OP_PROGRAM || op == FPC_OP_CHIP_ERASE)));
  endfunction
  task automatic final_report();
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp1(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t flag got %b exp %b", $time, g, e);
    end
  endtask
  task automatic cmpv(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t value got %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input fpc_op_e op, input logic [19:0] ad, input logic [15:0] dt, input logic fs,
                     input logic [9:0] nr);
    int i;
    @(posedge ref_clk_i);
    req_op_i <= op;
    req_addr_i <= ad;
    req_data_i <= dt;
    fast_supply_i <= fs;
    busy_reads <= nr;
    req_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    req_valid_i <= 1'b0;
    for (i = 0; i < 2000; i++) begin
      @(posedge ref_clk_i);
      if (done_o === 1'b1) break;
    end
    if (i == 2000) begin
      miscompares++;
      final_report();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    ref_clk_i = 1'b0;
    reset_n_i = 1'b0;
    req_valid_i = 1'b0;
    req_op_i = FPC_OP_READ;
    req_addr_i = 20'h00000;
    req_data_i = 16'h0000;
    fast_supply_i = 1'b0;
    busy_reads = 10'd0;
    miscompares = 0;
    comparisons = 0;
    seed = 32'h1389e440;
    repeat (6) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    for (k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      run(FPC_OP_READ, seed[19:0], 16'h0000, 1'b0, 10'd0);
      cmpv({4'h0, rdata_o}, {4'h0, seed[15:0] ^ 16'h3c3c});
    end
    for (k = 0; k < 3; k++) begin
      run(FPC_OP_ID_READ, id_addr[k], 16'h0000, 1'b0, 10'd0);
      cmpv({4'h0, rdata_o}, {12'h000, id_code[k]});
    end
    run(FPC_OP_ID_EXIT, 20'h00000, 16'h0000, 1'b0, 10'd0);
    run(FPC_OP_READ, 20'h00003, 16'h0000, 1'b0, 10'd0);
    cmpv({4'h0, rdata_o}, 20'h03c3f);
    // Power loss in identification mode must bring back plain reads
    run(FPC_OP_ID_READ, 20'h00001, 16'h0000, 1'b0, 10'd0);
    cmpv({4'h0, rdata_o}, {12'h000, id_code[1]});
    reset_n_i <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    cmp1(busy_o, 1'b0);
    run(FPC_OP_READ, 20'h00001, 16'h0000, 1'b0, 10'd0);
    cmpv({4'h0, rdata_o}, 20'h03c3d);
    // Slow supply tolerates a long poll that the fast limit would cut
    run(FPC_OP_PROGRAM, 20'h01234, 16'h00c3, 1'b0, 10'd70);
    cmp1(timeout_o, 1'b0);
    for (k = 0; k < 15; k++) begin
      seed = lfsr(seed);
      a = seed[19:0] | 20'h01000;
      f = k < 5 ? 1'b1 : seed[21];
      n = (k < 5 || seed[20]) ? 10'd70 : 10'd3;
      run(ops[k % 5], a, {seed[31:24], seed[7:0]}, f, n);
      cmp1(timeout_o, exp_to(ops[k % 5], f, n));
      cmpv({1'b0, evt, evt_data}, {1'b0, 3'(k % 5 + 1), 8'h00, k % 5 == 0 ? seed[7:0] : codes[k % 5]});
      cmpv(evt_addr, ops[k % 5] == FPC_OP_CHIP_ERASE ? 20'h00555 : a);
    end
    final_report();
  end
endmodule
